// ===== rtl/dica_cfg.svh
// constants for the direct-io converter adapter
`ifndef DICA_CFG_SVH
`define DICA_CFG_SVH

// clock rate and time conversion
`define DICA_CLK_MHZ       100
`define DICA_NS2CYC(ns)    (((ns) * `DICA_CLK_MHZ) / 1000)

// pulse times in ns
`define DICA_MUX_LOAD_NS   1000
`define DICA_ADC_CONV_NS   1000
`define DICA_ADC_STB_NS    4000
`define DICA_DAC_SEL_NS    1000
`define DICA_DAC_CONV_NS   1000
`define DICA_DO_UNIT_NS    1000

// pulse times in cycles
`define DICA_MUX_LOAD_CYC  `DICA_NS2CYC(`DICA_MUX_LOAD_NS)
`define DICA_ADC_CONV_CYC  `DICA_NS2CYC(`DICA_ADC_CONV_NS)
`define DICA_ADC_STB_CYC   `DICA_NS2CYC(`DICA_ADC_STB_NS)
`define DICA_DAC_SEL_CYC   `DICA_NS2CYC(`DICA_DAC_SEL_NS)
`define DICA_DAC_CONV_CYC  `DICA_NS2CYC(`DICA_DAC_CONV_NS)
`define DICA_DO_UNIT_CYC   `DICA_NS2CYC(`DICA_DO_UNIT_NS)

// effective address patterns (ea[15] is the leftmost bit)
`define DICA_AX_PAT        6'h2A
`define DICA_DI_PAT        13'h1580
`define DICA_DO_PAT        10'h2B0

// effective address field positions
`define DICA_EA_DLY        9
`define DICA_EA_RC         8
`define DICA_EA_D1         5
`define DICA_EA_D2         4

// reset values and result padding
`define DICA_ADC_RST       16'hFFFF
`define DICA_ADC_UNUSED    16'h0000

`endif

// ===== rtl/dica_pkg.sv
// types for the direct-io converter adapter
package dica_pkg;

	// analog input sequence
	typedef enum logic [2:0] {
		AI_IDLE,
		AI_MUX,
		AI_SETTLE,
		AI_TRIG,
		AI_CONV,
		AI_READ
	} dica_ai_t;

	// analog output sequence
	typedef enum logic [1:0] {
		DA_IDLE,
		DA_SEL,
		DA_TRIG,
		DA_CONV
	} dica_da_t;

	// pulse timer state
	typedef struct packed {
		logic [8:0] cnt;
	} dica_tmr_t;

	// adapter state
	typedef struct packed {
		dica_ai_t    ai;
		logic        ai_dly;
		logic [15:0] ai_res;
		logic [7:0]  mux_ch;
		logic        ai_done;
		dica_da_t    da;
		logic        da_dly;
		logic        da_cnv;
		logic [15:0] da_data;
		logic [7:0]  da_sel;
		logic        da_init;
		logic [31:0] dout;
		logic        ack;
		logic        err;
		logic [31:0] rdata;
		logic        cc3;
		logic        cc4;
	} dica_st_t;

endpackage

// ===== rtl/dica_pulse_timer.sv
// loadable pulse timer, active for len cycles
module dica_pulse_timer
	import dica_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       start,
	input  wire logic [8:0] len,
	// pulse
	output logic            active,
	output logic            last
);

	dica_tmr_t t_q;
	dica_tmr_t t_d;

	// load on start, then count down
	always_comb begin
		t_d = t_q;
		if (start) begin
			t_d.cnt = len;
		end else if (t_q.cnt != 9'h000) begin
			t_d.cnt = t_q.cnt - 9'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign active = (t_q.cnt != 9'h000);
	assign last   = (t_q.cnt == 9'h001);

endmodule

// ===== rtl/dica_top.sv
// direct-io converter adapter: analog in/out and digital io over apb
//
// The placing of the registers and register access over APB were left to the implementer.
`include "dica_cfg.svh"
module dica_top
	import dica_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// condition status
	output logic             cc3,
	output logic             cc4,
	// analog multiplexer
	output logic             mux_load,
	output logic [7:0]       mux_chan,
	input  wire logic        mux_ready,
	// analog-to-digital converter
	output logic             adc_convert,
	input  wire logic        adc_eoc,
	output logic             adc_strobe,
	input  wire logic [15:0] adc_data,
	input  wire logic        adc_trigger,
	output logic             adc_done,
	// digital-to-analog channel controllers
	output logic [15:0]      dac_data,
	output logic [7:0]       dac_sel,
	output logic             dac_sel_strobe,
	output logic             dac_convert,
	input  wire logic        dac_trigger,
	output logic             dac_init,
	// digital io
	input  wire logic [47:0] din_lines,
	input  wire logic        din_ready,
	output logic [31:0]      dout_data,
	output logic [3:0]       dout_pulse,
	input  wire logic        dout_ready
);

	dica_st_t    s_q;
	dica_st_t    s_d;
	logic [15:0] ea;
	logic        hit_ai;
	logic        hit_ao;
	logic        hit_di;
	logic        hit_do;
	logic        acc;
	logic        mux_go;
	logic        cnv_go;
	logic        stb_go;
	logic        sel_go;
	logic        dcv_go;
	logic [3:0]  pls_go;
	logic [8:0]  pls_len;
	logic        mux_last;
	logic        stb_last;
	logic        sel_last;
	logic        dcv_act;
	logic        dcv_last;
	logic        cnv_act;
	logic        cnv_last;
	logic        mux_act;
	logic        stb_act;
	logic        sel_act;

	// effective address sits on word address bits
	assign ea  = paddr[17:2];
	assign acc = psel & penable & ~s_q.ack;

	dica_ea_decode u_dec (
		.ea     (ea),
		.write  (pwrite),
		.hit_ai (hit_ai),
		.hit_ao (hit_ao),
		.hit_di (hit_di),
		.hit_do (hit_do)
	);

	dica_pulse_timer u_mux (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (mux_go),
		.len     (9'(`DICA_MUX_LOAD_CYC)),
		.active  (mux_act),
		.last    (mux_last)
	);

	dica_pulse_timer u_cnv (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (cnv_go),
		.len     (9'(`DICA_ADC_CONV_CYC)),
		.active  (cnv_act),
		.last    (cnv_last)
	);

	dica_pulse_timer u_stb (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (stb_go),
		.len     (9'(`DICA_ADC_STB_CYC)),
		.active  (stb_act),
		.last    (stb_last)
	);

	// channel select strobe
	dica_pulse_timer u_sel (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (sel_go),
		.len     (9'(`DICA_DAC_SEL_CYC)),
		.active  (sel_act),
		.last    (sel_last)
	);

	dica_pulse_timer u_dcv (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (dcv_go),
		.len     (9'(`DICA_DAC_CONV_CYC)),
		.active  (dcv_act),
		.last    (dcv_last)
	);

	// one pulse timer per output byte
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pls
			dica_pulse_timer u_pls (
				.pclk    (pclk),
				.presetn (presetn),
				.start   (pls_go[gi]),
				.len     (pls_len),
				.active  (dout_pulse[gi]),
				.last    ()
			);
		end
	endgenerate

	// next state: sequences first, then the bus access
	always_comb begin
		s_d       = s_q;
		s_d.ack   = 1'b0;
		s_d.ai_done = 1'b0;
		s_d.da_init = 1'b0;
		mux_go    = 1'b0;
		cnv_go    = 1'b0;
		stb_go    = 1'b0;
		sel_go    = 1'b0;
		dcv_go    = 1'b0;
		pls_go    = 4'h0;
		// width is (code + 1) microseconds
		pls_len   = ({7'h00, ea[`DICA_EA_D1:`DICA_EA_D2]} + 9'h001) * 9'(`DICA_DO_UNIT_CYC);

		// analog input sequence
		unique case (s_q.ai)
			AI_IDLE: begin
			end
			AI_MUX: begin
				// wait for the load pulse to finish
				if (mux_last) begin
					s_d.ai = AI_SETTLE;
				end
			end
			AI_SETTLE: begin
				if (mux_ready) begin
					if (s_q.ai_dly) begin
						s_d.ai = AI_TRIG;
					end else begin
						cnv_go = 1'b1;
						s_d.ai = AI_CONV;
					end
				end
			end
			AI_TRIG: begin
				if (adc_trigger) begin
					cnv_go = 1'b1;
					s_d.ai = AI_CONV;
				end
			end
			AI_CONV: begin
				if (adc_eoc) begin
					stb_go = 1'b1;
					s_d.ai = AI_READ;
				end
			end
			AI_READ: begin
				if (stb_last) begin
					s_d.ai_res  = adc_data;
					s_d.ai_done = 1'b1;
					s_d.ai      = AI_IDLE;
				end
			end
		endcase

		// analog output sequence
		unique case (s_q.da)
			DA_IDLE: begin
			end
			DA_SEL: begin
				if (sel_last) begin
					if (!s_q.da_cnv) begin
						s_d.da = DA_IDLE;
					end else if (s_q.da_dly) begin
						s_d.da = DA_TRIG;
					end else begin
						dcv_go      = 1'b1;
						s_d.da_init = 1'b1;
						s_d.da      = DA_CONV;
					end
				end
			end
			DA_TRIG: begin
				if (dac_trigger) begin
					dcv_go      = 1'b1;
					s_d.da_init = 1'b1;
					s_d.da      = DA_CONV;
				end
			end
			DA_CONV: begin
				if (dcv_last) begin
					s_d.da = DA_IDLE;
				end
			end
		endcase

		// bus access, acted on in first access cycle
		if (acc) begin
			s_d.ack   = 1'b1;
			s_d.err   = 1'b0;
			s_d.rdata = 32'h0000_0000;
			if (hit_ai) begin
				if (s_q.ai != AI_IDLE) begin
					s_d.cc3 = 1'b1;
				end else begin
					s_d.rdata = {16'h0000, s_q.ai_res | `DICA_ADC_UNUSED};
					s_d.cc3   = 1'b0;
					s_d.ai_dly = ea[`DICA_EA_DLY];
					if (!ea[`DICA_EA_RC]) begin
						s_d.mux_ch = ea[7:0];
						mux_go     = 1'b1;
						s_d.ai     = AI_MUX;
					end else if (ea[`DICA_EA_DLY]) begin
						s_d.ai = AI_TRIG;
					end else begin
						cnv_go = 1'b1;
						s_d.ai = AI_CONV;
					end
				end
			end else if (hit_ao) begin
				if (s_q.da != DA_IDLE) begin
					s_d.cc3 = 1'b0;
				end else begin
					s_d.cc3     = 1'b1;
					s_d.da_data = pwdata[15:0];
					s_d.da_sel  = ea[7:0];
					s_d.da_cnv  = ea[`DICA_EA_RC];
					s_d.da_dly  = ea[`DICA_EA_DLY];
					sel_go      = 1'b1;
					s_d.da      = DA_SEL;
				end
			end else if (hit_di) begin
				if (ea[2]) begin
					s_d.rdata = {16'h0000, din_lines[15:0]};
				end else if (ea[1]) begin
					s_d.rdata = {16'h0000, din_lines[31:16]};
				end else if (ea[0]) begin
					s_d.rdata = {16'h0000, din_lines[47:32]};
				end
				s_d.cc4 = din_ready;
			end else if (hit_do) begin
				// even bytes take high, odd low
				for (int k = 0; k < 4; k++) begin
					if (ea[3 - k]) begin
						s_d.dout[8 * k +: 8] = (k % 2 == 0) ? pwdata[15:8] : pwdata[7:0];
						pls_go[k]            = 1'b1;
					end
				end
				// false when ready, data still sent
				s_d.cc4 = ~dout_ready;
			end else begin
				s_d.err = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q        <= '0;
			s_q.ai     <= AI_IDLE;
			s_q.da     <= DA_IDLE;
			s_q.ai_res <= `DICA_ADC_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// apb answer one cycle into the access phase
	assign pready  = s_q.ack;
	assign pslverr = s_q.ack & s_q.err;
	assign prdata  = s_q.rdata;
	assign cc3     = s_q.cc3;
	assign cc4     = s_q.cc4;

	// analog input pins
	assign mux_load    = mux_act;
	assign mux_chan    = s_q.mux_ch;
	assign adc_convert = cnv_act;
	assign adc_strobe  = stb_act;
	assign adc_done    = s_q.ai_done;

	// analog output pins
	assign dac_data       = s_q.da_data;
	assign dac_sel        = s_q.da_sel;
	assign dac_sel_strobe = sel_act;
	assign dac_convert    = dcv_act;
	assign dac_init       = s_q.da_init;

	// digital output data
	assign dout_data = s_q.dout;

endmodule

// ===== rtl/dica_ea_decode.sv
// effective address decoder for the adapter
`include "dica_cfg.svh"
module dica_ea_decode
	import dica_pkg::*;
(
	// address and direction
	input  wire logic [15:0] ea,
	input  wire logic        write,
	// decoded kinds
	output logic             hit_ai,
	output logic             hit_ao,
	output logic             hit_di,
	output logic             hit_do
);

	// analog patterns share the high field
	assign hit_ai = ~write & (ea[15:10] == `DICA_AX_PAT);
	assign hit_ao =  write & (ea[15:10] == `DICA_AX_PAT);
	// digital patterns fix most of the word
	assign hit_di = ~write & (ea[15:3] == `DICA_DI_PAT);
	assign hit_do =  write & (ea[15:6] == `DICA_DO_PAT);

endmodule

// ===== test/dica_chk.sv
// port-level assertions for the converter adapter
module dica_chk (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// analog input side
	input wire logic       mux_load,
	input wire logic [7:0] mux_chan,
	input wire logic       adc_convert,
	input wire logic       adc_strobe,
	input wire logic       adc_done,
	// analog output side
	input wire logic       dac_convert,
	input wire logic       dac_init
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_mux_len: assert property ($rose(mux_load) |-> ##99 mux_load ##1 !mux_load)
		else $error("mux load length");
	chk_chan_hold: assert property (mux_load && $past(mux_load) |-> $stable(mux_chan))
		else $error("mux channel moved");
	chk_conv_len: assert property ($rose(adc_convert) |-> ##99 adc_convert ##1 !adc_convert)
		else $error("convert length");
	chk_strobe_len: assert property ($rose(adc_strobe) |-> ##[399:399] adc_strobe ##1 !adc_strobe)
		else $error("strobe length");
	chk_done_after: assert property ($fell(adc_strobe) |-> ##[0:1] adc_done)
		else $error("no done after read");
	chk_done_one: assert property (adc_done |=> !adc_done)
		else $error("done too long");
	chk_init_edge: assert property ($rose(dac_convert) |-> dac_init ##1 !dac_init)
		else $error("init pulse wrong");
	chk_xfer_len: assert property ($rose(dac_convert) |-> ##99 dac_convert ##1 !dac_convert)
		else $error("transfer length");
endmodule

bind dica_top dica_chk i_dica_chk (.pclk, .presetn, .mux_load, .mux_chan, .adc_convert,
	.adc_strobe, .adc_done, .dac_convert, .dac_init);

// ===== test/dica_far.sv
// far-side model: multiplexer and converter
module dica_far (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// controls from the adapter
	input  wire logic        mux_load,
	input  wire logic        adc_convert,
	input  wire logic        adc_strobe,
	// behaviour settings
	input  wire logic [15:0] sample,
	input  wire logic [7:0]  lag,
	// answers
	output logic             mux_ready,
	output logic             adc_eoc,
	output logic [15:0]      adc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		mux_ready = 1'h0;
		adc_eoc = 1'h0;
	end
	always @(negedge mux_load) begin
		if (presetn === 1'h1) begin
			repeat (lag) @(posedge pclk);
			mux_ready <= 1'h1;
			repeat (100) @(posedge pclk);
			mux_ready <= 1'h0;
		end
	end
	always @(posedge adc_convert) begin
		if (presetn === 1'h1) begin
			repeat (lag) @(posedge pclk);
			adc_eoc <= 1'h1;
			repeat (50) @(posedge pclk);
			adc_eoc <= 1'h0;
		end
	end
	assign adc_data = adc_strobe ? sample : ~sample;
endmodule

// ===== test/testbench.sv
// self-checking bench for the converter adapter
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd, dout_data;
	logic        pready, pslverr, cc3, cc4, err, c3, c4;
	logic        mux_load, mux_ready, adc_convert, adc_eoc, adc_strobe, adc_trigger, adc_done;
	logic [7:0]  mux_chan, dac_sel, lag;
	logic [15:0] adc_data, dac_data, sample;
	logic        dac_sel_strobe, dac_convert, dac_trigger, dac_init, din_ready, dout_ready;
	logic [47:0] din_lines;
	logic [3:0]  dout_pulse;
	int          n_fail = 0, n_compared = 0, n_init = 0, n_hi = 0;

	dica_top i_dica_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cc3, .cc4, .mux_load, .mux_chan, .mux_ready, .adc_convert, .adc_eoc,
		.adc_strobe, .adc_data, .adc_trigger, .adc_done, .dac_data, .dac_sel, .dac_sel_strobe,
		.dac_convert, .dac_trigger, .dac_init, .din_lines, .din_ready, .dout_data, .dout_pulse,
		.dout_ready);
	dica_far i_dica_far (.pclk, .presetn, .mux_load, .adc_convert, .adc_strobe, .sample, .lag,
		.mux_ready, .adc_eoc, .adc_data);

	// clock
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	// pulse counters
	always @(posedge pclk) if (dac_init === 1'h1) n_init <= n_init + 1;
	always @(posedge pclk) if (dout_pulse[0] === 1'h1) n_hi <= n_hi + 1;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer, waits for ready
	task automatic apb(input logic w, input logic [15:0] ea, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {ea, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1);
		chk("apb cycles", 32'h2, n);
		rd = prdata;
		err = pslverr;
		c3 = cc3;
		c4 = cc4;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic wait_done;
		repeat (3000) if (adc_done !== 1'h1) @(posedge pclk);
		chk("adc done", 32'h1, {31'h0, adc_done});
		@(posedge pclk);
	endtask

	// analog input: fresh, busy, reuse
	task automatic s_ai;
		apb(1'h0, 16'ha85a, 32'h0);
		chk("ok err", 32'h0, {31'h0, err});
		chk("first", 32'hffff, {16'h0, rd[15:0]});
		chk("idle cc3", 32'h0, {31'h0, c3});
		chk("mux chan", 32'h5a, {24'h0, mux_chan});
		chk("mux load", 32'h1, {31'h0, mux_load});
		chk("no early conv", 32'h0, {31'h0, adc_convert});
		apb(1'h0, 16'ha811, 32'h0);
		chk("busy cc3", 32'h1, {31'h0, c3});
		chk("busy data", 32'h0, rd);
		chk("busy chan", 32'h5a, {24'h0, mux_chan});
		wait_done();
		apb(1'h0, 16'ha933, 32'h0);
		chk("result", 32'hc3a5, {16'h0, rd[15:0]});
		chk("reuse no load", 32'h0, {31'h0, mux_load});
		repeat (20) if (adc_convert !== 1'h1) @(posedge pclk);
		chk("reuse conv", 32'h1, {31'h0, adc_convert});
		chk("reuse chan", 32'h5a, {24'h0, mux_chan});
		wait_done();
	endtask

	// analog input held for trigger, slow far side
	task automatic s_trig;
		lag <= 8'h3c;
		sample <= 16'h0f1e;
		apb(1'h0, 16'hab77, 32'h0);
		chk("trig first", 32'hc3a5, {16'h0, rd[15:0]});
		repeat (300) @(posedge pclk);
		chk("held conv", 32'h0, {31'h0, adc_convert});
		apb(1'h0, 16'hab77, 32'h0);
		chk("wait cc3", 32'h1, {31'h0, c3});
		adc_trigger <= 1'h1;
		@(posedge pclk);
		adc_trigger <= 1'h0;
		wait_done();
		apb(1'h0, 16'hab77, 32'h0);
		chk("late result", 32'h0f1e, {16'h0, rd[15:0]});
	endtask

	// analog output: load only, now, pending, on trigger
	task automatic s_ao;
		int k;
		k = n_init;
		apb(1'h1, 16'ha87c, 32'h0000_8e71);
		chk("dac sel", 32'h7c, {24'h0, dac_sel});
		chk("dac data", 32'h8e71, {16'h0, dac_data});
		chk("sel strobe", 32'h1, {31'h0, dac_sel_strobe});
		repeat (300) @(posedge pclk);
		chk("no xfer", k, n_init);
		apb(1'h1, 16'ha9a3, 32'h0000_1234);
		apb(1'h1, 16'ha955, 32'h0000_5555);
		chk("pend cc3", 32'h0, {31'h0, c3});
		chk("pend sel", 32'ha3, {24'h0, dac_sel});
		chk("pend data", 32'h1234, {16'h0, dac_data});
		repeat (300) if (dac_convert !== 1'h1) @(posedge pclk);
		chk("xfer", 32'h1, {31'h0, dac_convert});
		repeat (300) @(posedge pclk);
		chk("init count", k + 1, n_init);
		apb(1'h1, 16'hab0f, 32'h0000_00ff);
		repeat (300) @(posedge pclk);
		chk("held xfer", k + 1, n_init);
		dac_trigger <= 1'h1;
		@(posedge pclk);
		dac_trigger <= 1'h0;
		repeat (300) if (dac_convert !== 1'h1) @(posedge pclk);
		chk("trig xfer", 32'h1, {31'h0, dac_convert});
		repeat (300) @(posedge pclk);
	endtask

	// digital groups, bytes and pulse widths
	task automatic s_dio;
		for (int i = 0; i < 3; i++) begin
			apb(1'h0, {13'h1580, 3'h4 >> i}, 32'h0);
			chk("din group", {16'h0, din_lines[16*i +: 16]}, {16'h0, rd[15:0]});
			chk("din cc4", 32'h1, {31'h0, c4});
		end
		for (int d = 0; d < 4; d++) begin
			n_hi = 0;
			apb(1'h1, {10'h2b0, d[1:0], 4'hc}, 32'h0000_a55a);
			chk("dout low", 32'h5aa5, {16'h0, dout_data[15:0]});
			chk("pulse sel", 32'h3, {28'h0, dout_pulse});
			chk("dout cc4", 32'h0, {31'h0, c4});
			repeat (500) @(posedge pclk);
			chk("pulse width", (d + 1) * 100, n_hi);
		end
		apb(1'h1, 16'hac13, 32'h0000_1e2d);
		chk("dout high", 32'h2d1e, {16'h0, dout_data[31:16]});
		chk("pulse sel hi", 32'hc, {28'h0, dout_pulse});
		din_ready <= 1'h0;
		dout_ready <= 1'h0;
		apb(1'h0, 16'hac01, 32'h0);
		chk("din not ready", 32'h0, {31'h0, c4});
		apb(1'h1, 16'hac0c, 32'h0000_0102);
		chk("dout not ready", 32'h1, {31'h0, c4});
		chk("dout sent", 32'h0201, {16'h0, dout_data[15:0]});
		apb(1'h0, 16'h1234, 32'h0);
		chk("bad err", 32'h1, {31'h0, err});
		chk("bad chan", 32'h5a, {24'h0, mux_chan});
	endtask

	task automatic complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog
	initial begin
		#200000;
		n_fail++;
		complete_run();
	end

	// main sequence
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 18'h0;
		pwdata = 32'h0;
		adc_trigger = 1'h0;
		dac_trigger = 1'h0;
		din_lines = 48'h9abc_5678_1234;
		din_ready = 1'h1;
		dout_ready = 1'h1;
		sample = 16'hc3a5;
		lag = 8'h05;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		s_ai();
		s_trig();
		s_ao();
		s_dio();
		complete_run();
	end
endmodule
